// File: slh_pkg.sv
package slh_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [3:0]  SLH_ADR_CTRL   = 4'h0;
    localparam logic [3:0]  SLH_ADR_FLAG   = 4'h4;
    localparam logic [3:0]  SLH_ADR_STAT   = 4'h8;

    // Control register fields
    localparam int          SLH_C_NOLIMP   = 0;
    localparam int          SLH_C_MON_EN   = 1;
    localparam int          SLH_C_FMON_EN  = 2;
    localparam int          SLH_C_DLY_EN   = 3;
    localparam int          SLH_C_PSTOP    = 4;
    localparam int          SLH_C_BSEL     = 5;
    localparam int          SLH_C_MSEL     = 6;
    localparam int          SLH_C_AUTO     = 7;
    localparam int          SLH_C_IRQ_EN   = 8;
    localparam int          SLH_CTRL_W     = 9;
    // Reset turns the monitor on and leaves limp-home allowed
    localparam logic [8:0]  SLH_CTRL_RST   = 9'h002;

    // Flag register fields
    localparam int          SLH_F_IRQ      = 0;
    localparam int          SLH_F_LIMP     = 1;

    // Status register fields
    localparam int          SLH_S_ST_LO    = 0;
    localparam int          SLH_S_VCO      = 2;
    localparam int          SLH_S_PSEUDO   = 3;
    localparam int          SLH_S_PRES     = 4;
    localparam int          SLH_S_CNT_LO   = 16;

    // -------------------------------------------------------------------
    // Counter timing, in counter clock ticks
    // -------------------------------------------------------------------
    localparam int          SLH_CNT_W      = 13;
    localparam logic [12:0] SLH_CNT_MID    = 13'h0fff;
    localparam logic [12:0] SLH_CNT_SHORT  = 13'h000f;

    typedef enum logic [1:0] {
        SLH_ST_RUN   = 2'b00,
        SLH_ST_STOP  = 2'b01,
        SLH_ST_DELAY = 2'b11,
        SLH_ST_LIMP  = 2'b10
    } slh_state_e;

endpackage : slh_pkg

// File: slh_xcnt.sv
`timescale 1ns/1ps
`default_nettype none

module slh_xcnt
    import slh_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              tick_i,
    input  wire logic              clr_i,
    output logic [SLH_CNT_W-1:0]   cnt_o,
    output logic                   mid_o
);

    typedef struct packed {
        logic [SLH_CNT_W-1:0] cnt;
    } slh_xcnt_s;

    slh_xcnt_s q;
    slh_xcnt_s d;

    // -------------------------------------------------------------------
    // Free-running stage counter
    // -------------------------------------------------------------------
    always_comb begin
        d = q;
        if (clr_i) begin
            d.cnt = '0;
        end else if (tick_i) begin
            d.cnt = q.cnt + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt_o = q.cnt;
    // Mid-count: the tick that brings the count to 4096
    assign mid_o = tick_i & ~clr_i & (q.cnt == SLH_CNT_MID);

endmodule : slh_xcnt

`default_nettype wire

// File: slh_stop_ctrl.sv
// Function
// - No limp-home, monitors off: stop instruction stops; exit on external clock.
// - Same case with delay bit: restart after 4096 counter ticks.
// - No limp-home, any monitor on: stop raises monitor reset instead.
// - Limp-home allowed: monitors masked while stopped, forced on while the counter runs on the VCO.
// - Delayed limp exit: 4096 VCO ticks, then external clock or limp with flags.
// - In limp-home, sample monitor at every counter mid-count.
// - Clock found: leave limp, clear status, set change flag, irq if enabled.
// - Leaving limp restores bus and module selects; relock PLL if auto and bus select set.
// - Fast exit with crystal: release at once, run on limp clock.
// - Fast exit with square-wave clock: release at once, never set status.
// - Pseudo-stop bit set: stop enters pseudo-stop, oscillator keeps running.
// - Pseudo-stop leaves on same wake events as stop.
// - Delayed pseudo-stop exit with limp: forced limp, check after 4096 ticks.
// - Crystal failed in pseudo-stop: exit in limp with flags, keep polling.
// - Limp allowed, delay clear: pseudo-stop exit without delay.
// - No limp, monitors off, delay set: pseudo-stop exit after 4096 ticks.
// - Same case, delay clear: exit after only 16 ticks.
// - Delay bit selects 4096-tick wait, clear selects none, or 16 ticks for pseudo-stop without limp-home.
// - Change flag cleared only by writing one to it.
// - Status flag reads one while running on limp clock.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module slh_stop_ctrl
    import slh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Core and wake sources, same clock
    input  wire logic        stop_exec_i,
    input  wire logic        irq_wake_i,
    input  wire logic        nonmaskable_ext_irq_i,
    input  wire logic        key_wake_j_i,
    input  wire logic        key_wake_h_i,
    input  wire logic        can_wake_i,
    input  wire logic        vco_tick_i,
    // Pins from the oscillator side
    input  wire logic        ext_osc_clk_i,
    input  wire logic        clk_present_i,
    // Clock generator controls
    output logic             stopped_o,
    output logic             cpu_run_o,
    output logic             osc_run_o,
    output logic             counter_from_vco_o,
    output logic             clk_monitor_en_o,
    output logic             clk_mon_reset_o,
    output logic             bus_clk_sel_pll_o,
    output logic             module_clk_sel_o,
    output logic             pll_relock_o,
    output logic             limp_active_o,
    output logic             limp_irq_o
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        slh_state_e             st;
        logic                   pseudo;
        logic                   vco_src;
        logic                   short_dly;
        logic [SLH_CTRL_W-1:0]  ctrl;
        logic                   irq_flag;
        logic                   limp;
        logic [2:0]             osc_sync;
        logic                   osc_lvl;
        logic [2:0]             pres_sync;
        logic                   pres;
        logic                   ack;
        logic [31:0]            rdat;
        logic                   stopped;
        logic                   cpu_run;
        logic                   osc_run;
        logic                   cme_out;
        logic                   mon_rst;
        logic                   bsel;
        logic                   msel;
        logic                   relock;
        logic                   irq;
    } slh_regs_s;

    slh_regs_s              q;
    slh_regs_s              d;
    logic                   cnt_tick;
    logic                   cnt_clr;
    logic [SLH_CNT_W-1:0]   cnt;
    logic                   cnt_mid;
    logic                   ext_tick;
    logic                   wake;
    logic                   no_limp;
    logic                   mon_on;
    logic                   dly_on;
    logic                   dly_done;
    logic                   bus_req;

    function automatic logic [31:0] rd_mux(input logic [3:0] adr, input slh_regs_s s,
                                           input logic [SLH_CNT_W-1:0] c);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (adr)
            SLH_ADR_CTRL: begin
                r[SLH_CTRL_W-1:0] = s.ctrl;
            end
            SLH_ADR_FLAG: begin
                r[SLH_F_IRQ]  = s.irq_flag;
                r[SLH_F_LIMP] = s.limp;
            end
            SLH_ADR_STAT: begin
                r[SLH_S_ST_LO+1:SLH_S_ST_LO]            = s.st;
                r[SLH_S_VCO]                            = s.vco_src;
                r[SLH_S_PSEUDO]                         = s.pseudo;
                r[SLH_S_PRES]                           = s.pres;
                r[SLH_S_CNT_LO+SLH_CNT_W-1:SLH_S_CNT_LO] = c;
            end
            default: begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction : rd_mux

    // -------------------------------------------------------------------
    // Stage counter
    // -------------------------------------------------------------------
    slh_xcnt u_xcnt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (cnt_tick),
        .clr_i  (cnt_clr),
        .cnt_o  (cnt),
        .mid_o  (cnt_mid)
    );

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        d          = q;
        d.ack      = 1'b0;
        d.mon_rst  = 1'b0;
        d.relock   = 1'b0;
        cnt_clr    = 1'b0;

        // Pin synchronisers; a level counts once stages two and three agree
        d.osc_sync  = {q.osc_sync[1:0], ext_osc_clk_i};
        d.pres_sync = {q.pres_sync[1:0], clk_present_i};
        if (q.pres_sync[2] == q.pres_sync[1]) begin
            d.pres = q.pres_sync[2];
        end
        if (q.osc_sync[2] == q.osc_sync[1]) begin
            d.osc_lvl = q.osc_sync[2];
        end
        // One tick per settled rising level, so a slow edge cannot count twice
        ext_tick = q.osc_sync[2] & q.osc_sync[1] & ~q.osc_lvl;

        // Counter runs on the VCO in limp-home and in the limp-allowed exit delay, else on the oscillator
        cnt_tick = q.vco_src ? vco_tick_i : ext_tick;

        no_limp  = q.ctrl[SLH_C_NOLIMP];
        mon_on   = q.ctrl[SLH_C_MON_EN] | q.ctrl[SLH_C_FMON_EN];
        dly_on   = q.ctrl[SLH_C_DLY_EN];
        wake     = irq_wake_i | nonmaskable_ext_irq_i | key_wake_j_i
                 | key_wake_h_i | can_wake_i;
        dly_done = q.short_dly ? (cnt_tick & (cnt == SLH_CNT_SHORT)) : cnt_mid;

        // ---------------------------------------------------------------
        // Register bus
        // ---------------------------------------------------------------
        bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
        if (bus_req) begin
            d.ack  = 1'b1;
            d.rdat = rd_mux(wb_adr_i, q, cnt);
            if (wb_we_i && wb_adr_i == SLH_ADR_CTRL) begin
                if (wb_sel_i[0]) begin
                    d.ctrl[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    d.ctrl[SLH_C_IRQ_EN] = wb_dat_i[SLH_C_IRQ_EN];
                end
            end
            if (wb_we_i && wb_adr_i == SLH_ADR_FLAG && wb_sel_i[0]
                    && wb_dat_i[SLH_F_IRQ]) begin
                d.irq_flag = 1'b0;
            end
        end

        // ---------------------------------------------------------------
        // Stop entry and exit sequencing
        // ---------------------------------------------------------------
        unique case (q.st)
            SLH_ST_RUN: begin
                if (stop_exec_i) begin
                    if (no_limp && mon_on) begin
                        d.mon_rst = 1'b1;
                    end else begin
                        d.st     = SLH_ST_STOP;
                        d.pseudo = q.ctrl[SLH_C_PSTOP];
                    end
                end
            end
            SLH_ST_STOP: begin
                if (wake) begin
                    if (!no_limp) begin
                        if (dly_on) begin
                            d.st        = SLH_ST_DELAY;
                            d.vco_src   = 1'b1;
                            d.short_dly = 1'b0;
                            cnt_clr     = 1'b1;
                        end else if (q.pres) begin
                            d.st = SLH_ST_RUN;
                        end else begin
                            d.st      = SLH_ST_LIMP;
                            d.vco_src = 1'b1;
                            d.limp    = 1'b1;
                        end
                    end else if (dly_on || q.pseudo) begin
                        // Only oscillator edges advance this wait
                        d.st        = SLH_ST_DELAY;
                        d.vco_src   = 1'b0;
                        d.short_dly = ~dly_on;
                        cnt_clr     = 1'b1;
                    end else begin
                        d.st = SLH_ST_RUN;
                    end
                end
            end
            SLH_ST_DELAY: begin
                if (dly_done) begin
                    if (!q.vco_src) begin
                        d.st = SLH_ST_RUN;
                    end else if (q.pres) begin
                        d.st      = SLH_ST_RUN;
                        d.vco_src = 1'b0;
                    end else begin
                        d.st   = SLH_ST_LIMP;
                        d.limp = 1'b1;
                    end
                end
            end
            SLH_ST_LIMP: begin
                // Poll only at mid-count, so one check per counter period
                if (cnt_mid && q.pres) begin
                    d.st      = SLH_ST_RUN;
                    d.limp    = 1'b0;
                    d.vco_src = 1'b0;
                    d.relock  = q.ctrl[SLH_C_AUTO] & q.ctrl[SLH_C_BSEL];
                end
            end
        endcase

        // Hardware set wins over a software clear in the same cycle
        if (d.limp != q.limp) begin
            d.irq_flag = 1'b1;
        end

        // ---------------------------------------------------------------
        // Registered outputs
        // ---------------------------------------------------------------
        d.stopped = (d.st == SLH_ST_STOP) || (d.st == SLH_ST_DELAY);
        d.cpu_run = (d.st == SLH_ST_RUN) || (d.st == SLH_ST_LIMP);
        d.osc_run = !((d.st == SLH_ST_STOP) && !d.pseudo);
        if (d.vco_src) begin
            d.cme_out = 1'b1;
        end else if (d.st == SLH_ST_STOP && !d.ctrl[SLH_C_NOLIMP]) begin
            d.cme_out = 1'b0;
        end else begin
            d.cme_out = d.ctrl[SLH_C_MON_EN] | d.ctrl[SLH_C_FMON_EN];
        end
        // Forced selects on the VCO; released ones follow software again
        d.bsel = d.vco_src ? 1'b1 : d.ctrl[SLH_C_BSEL];
        d.msel = d.vco_src ? 1'b0 : d.ctrl[SLH_C_MSEL];
        d.irq  = d.irq_flag & d.ctrl[SLH_C_IRQ_EN];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q          <= '0;
            q.st       <= SLH_ST_RUN;
            q.ctrl     <= SLH_CTRL_RST;
            q.cpu_run  <= 1'b1;
            q.osc_run  <= 1'b1;
            q.cme_out  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------
    // Ports
    // -------------------------------------------------------------------
    assign wb_dat_o           = q.rdat;
    assign wb_ack_o           = q.ack;
    assign stopped_o          = q.stopped;
    assign cpu_run_o          = q.cpu_run;
    assign osc_run_o          = q.osc_run;
    assign counter_from_vco_o = q.vco_src;
    assign clk_monitor_en_o   = q.cme_out;
    assign clk_mon_reset_o    = q.mon_rst;
    assign bus_clk_sel_pll_o  = q.bsel;
    assign module_clk_sel_o   = q.msel;
    assign pll_relock_o       = q.relock;
    assign limp_active_o      = q.limp;
    assign limp_irq_o         = q.irq;

endmodule : slh_stop_ctrl

`default_nettype wire

// File: slh_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

module slh_osc_model (
    input  wire logic clk_i,
    input  wire logic osc_run_i,
    input  wire logic crystal_ok_i,
    input  wire logic square_i,
    output logic      ext_osc_clk_o,
    output logic      clk_present_o
);
    logic [1:0] ph_q = 2'h0;

    // Pin stands still while the source is stopped or failed
    always @(posedge clk_i) begin
        if ((osc_run_i || square_i) && crystal_ok_i) begin
            ph_q <= ph_q + 2'h1;
        end
    end
    assign ext_osc_clk_o = ph_q[1];
    assign clk_present_o = (osc_run_i || square_i) && crystal_ok_i;
endmodule : slh_osc_model

`default_nettype wire

// File: slh_stop_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module slh_stop_ctrl_properties
    import slh_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stop_exec_i,
    input wire logic        stopped_o,
    input wire logic        cpu_run_o,
    input wire logic        osc_run_o,
    input wire logic        counter_from_vco_o,
    input wire logic        clk_monitor_en_o,
    input wire logic        clk_mon_reset_o,
    input wire logic        bus_clk_sel_pll_o,
    input wire logic        module_clk_sel_o,
    input wire logic        pll_relock_o,
    input wire logic        limp_active_o,
    input wire logic        limp_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Shadow of the control word; lags the real one by a cycle
    logic [8:0] ctrl_q;
    logic       run;
    logic       lock;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= SLH_CTRL_RST;
        end else if (wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == SLH_ADR_CTRL) begin
            if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl_q[8] <= wb_dat_i[8];
        end
    end
    assign run  = cpu_run_o && !limp_active_o;
    assign lock = ctrl_q[SLH_C_NOLIMP] && (ctrl_q[SLH_C_MON_EN] || ctrl_q[SLH_C_FMON_EN]);

    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    property p_ack_drop;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
    property p_unmapped;
        wb_ack_o && !wb_we_i && !(wb_adr_i inside {4'h0, 4'h4, 4'h8}) |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mon_rst;
        stop_exec_i && run && lock |=> clk_mon_reset_o && !stopped_o;
    endproperty
    a_mon_rst: assert property (p_mon_rst) else $error("no monitor reset");
    property p_enter;
        stop_exec_i && run && !lock |=> stopped_o && !cpu_run_o
            && osc_run_o == ctrl_q[SLH_C_PSTOP];
    endproperty
    a_enter: assert property (p_enter) else $error("stop entry wrong");
    property p_mask;
        stopped_o && !counter_from_vco_o && !ctrl_q[SLH_C_NOLIMP] |-> !clk_monitor_en_o;
    endproperty
    a_mask: assert property (p_mask) else $error("monitor not masked");
    property p_forced;
        counter_from_vco_o |-> bus_clk_sel_pll_o && !module_clk_sel_o;
    endproperty
    a_forced: assert property (p_forced) else $error("selects not forced");
    property p_limp_mon;
        limp_active_o |-> clk_monitor_en_o;
    endproperty
    a_limp_mon: assert property (p_limp_mon) else $error("monitor off in limp");
    property p_irq;
        $changed(limp_active_o) && ctrl_q[SLH_C_IRQ_EN] |-> ##[0:1] limp_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("no change interrupt");
    property p_relock;
        $fell(limp_active_o) && ctrl_q[SLH_C_AUTO] && ctrl_q[SLH_C_BSEL] |-> ##[0:1] pll_relock_o;
    endproperty
    a_relock: assert property (p_relock) else $error("no relock");
    property p_restore;
        $fell(counter_from_vco_o) |-> ##[0:1] bus_clk_sel_pll_o == ctrl_q[SLH_C_BSEL];
    endproperty
    a_restore: assert property (p_restore) else $error("select not restored");

    c_limp: cover property ($rose(limp_active_o));
    c_mon: cover property (clk_mon_reset_o);
    c_relock: cover property (pll_relock_o);
endmodule : slh_stop_ctrl_properties

bind slh_stop_ctrl slh_stop_ctrl_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_exec_i, .stopped_o,
    .cpu_run_o, .osc_run_o, .counter_from_vco_o, .clk_monitor_en_o, .clk_mon_reset_o,
    .bus_clk_sel_pll_o, .module_clk_sel_o, .pll_relock_o, .limp_active_o, .limp_irq_o);

`default_nettype wire

// File: slh_stop_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module slh_stop_ctrl_tb_top;
    import slh_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [4:0] wk = 5'h0;
    logic stop_exec_i = 1'b0, vco_tick_i = 1'b1, ok = 1'b1, square = 1'b0;
    logic wb_ack_o, ext_osc_clk_i, clk_present_i, stopped_o, cpu_run_o, osc_run_o;
    logic counter_from_vco_o, clk_monitor_en_o, clk_mon_reset_o, bus_clk_sel_pll_o;
    logic module_clk_sel_o, pll_relock_o, limp_active_o, limp_irq_o;
    int bad_count = 0, compares = 0;

    always #50 clk_i = ~clk_i;

    slh_stop_ctrl uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_exec_i, .irq_wake_i(wk[0]),
        .nonmaskable_ext_irq_i(wk[1]), .key_wake_j_i(wk[2]), .key_wake_h_i(wk[3]),
        .can_wake_i(wk[4]), .vco_tick_i, .ext_osc_clk_i, .clk_present_i, .stopped_o, .cpu_run_o,
        .osc_run_o, .counter_from_vco_o, .clk_monitor_en_o, .clk_mon_reset_o, .bus_clk_sel_pll_o,
        .module_clk_sel_o, .pll_relock_o, .limp_active_o, .limp_irq_o);
    slh_osc_model u_osc (.clk_i, .osc_run_i(osc_run_o), .crystal_ok_i(ok), .square_i(square),
        .ext_osc_clk_o(ext_osc_clk_i), .clk_present_o(clk_present_i));

    task automatic end_of_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        // Request stands until ack is sampled high at a rising edge
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            end_of_test();
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // One-cycle stop or wake request; ends where the answer has settled
    task automatic pulse(input logic s, input logic [4:0] w);
        @(posedge clk_i);
        stop_exec_i <= s;
        wk <= w;
        @(posedge clk_i);
        stop_exec_i <= 1'b0;
        wk <= 5'h0;
        @(negedge clk_i);
    endtask : pulse

    task automatic wait_sig(input logic lmp, input int max, output int n);
        n = 0;
        while ((lmp ? limp_active_o : !cpu_run_o) !== 1'b0 && n < max) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= max) begin
            bad_count++;
            end_of_test();
        end
    endtask : wait_sig

    task automatic run_exit(input logic [8:0] c, input int w, input int lo, input int hi,
                            input logic lexp);
        logic [31:0] r;
        int n;
        wb(1'b1, SLH_ADR_CTRL, {23'h0, c}, r);
        pulse(1'b1, 5'h0);
        check(stopped_o, 1'b1);
        check(osc_run_o, c[SLH_C_PSTOP]);
        repeat (8) @(posedge clk_i);
        pulse(1'b0, 5'h1 << w);
        wait_sig(1'b0, hi + 4, n);
        check(n >= lo && n <= hi, 1'b1);
        check(limp_active_o, lexp);
    endtask : run_exit

    task automatic t_regs();
        logic [31:0] r;
        wb(1'b0, SLH_ADR_CTRL, 32'h0, r);
        check(r, 32'h2);
        wb(1'b1, 4'hc, 32'hffff_ffff, r);
        wb(1'b0, 4'hc, 32'h0, r);
        check(r, 32'h0);
    endtask : t_regs

    task automatic t_mon_reset(input logic [8:0] c);
        logic [31:0] r;
        wb(1'b1, SLH_ADR_CTRL, {23'h0, c}, r);
        pulse(1'b1, 5'h0);
        check({clk_mon_reset_o, cpu_run_o, stopped_o}, 3'b110);
    endtask : t_mon_reset

    task automatic t_limp_poll(input logic [8:0] c, input int lo, input int hi);
        logic [31:0] r;
        int n;
        run_exit(c, 2, lo, hi, 1'b1);
        check(limp_irq_o, c[SLH_C_IRQ_EN]);
        check({counter_from_vco_o, bus_clk_sel_pll_o, module_clk_sel_o, clk_monitor_en_o}, 4'hd);
        wb(1'b0, SLH_ADR_FLAG, 32'h0, r);
        check(r, 32'h3);
        wb(1'b1, SLH_ADR_FLAG, 32'h1, r);
        wb(1'b0, SLH_ADR_FLAG, 32'h0, r);
        check(r, 32'h2);
        ok <= 1'b1;
        wait_sig(1'b1, 8300, n);
        check(n > 7000, 1'b1);
        check({cpu_run_o, limp_irq_o}, {1'b1, c[SLH_C_IRQ_EN]});
        check(bus_clk_sel_pll_o, c[SLH_C_BSEL]);
        check(module_clk_sel_o, c[SLH_C_MSEL]);
        check(pll_relock_o, c[SLH_C_AUTO] & c[SLH_C_BSEL]);
        wb(1'b1, SLH_ADR_FLAG, 32'h1, r);
    endtask : t_limp_poll

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_mon_reset(9'h003);
        t_mon_reset(9'h015);
        run_exit(9'h001, 0, 0, 1, 1'b0);
        run_exit(9'h009, 2, 16370, 16400, 1'b0);
        run_exit(9'h011, 4, 56, 72, 1'b0);
        run_exit(9'h019, 1, 16370, 16400, 1'b0);
        run_exit(9'h010, 3, 0, 1, 1'b0);
        run_exit(9'h018, 0, 4090, 4104, 1'b0);
        ok <= 1'b0;
        t_limp_poll(9'h1e8, 4090, 4104);
        ok <= 1'b0;
        t_limp_poll(9'h018, 4090, 4104);
        t_limp_poll(9'h000, 0, 1);
        square <= 1'b1;
        run_exit(9'h000, 4, 0, 1, 1'b0);
        end_of_test();
    end
endmodule : slh_stop_ctrl_tb_top

`default_nettype wire
